/* File: verilog/dtpc_pkg.sv */
// Constants and types shared by the dual timer, PWM and capture unit.
// Assumes a 32-bit APB master; each register index maps to one word.
package dtpc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [23:0] IDX_COUNTER_ONE = 24'hffff40;
  localparam logic [23:0] IDX_RELOAD_CAPTURE_A = 24'hffff42;
  localparam logic [23:0] IDX_RELOAD_B = 24'hffff44;
  localparam logic [23:0] IDX_COUNTER_TWO = 24'hffff46;
  localparam logic [23:0] IDX_CLOCK_DIVIDER = 24'hffff48;
  localparam logic [23:0] IDX_SOURCE_SELECT = 24'hffff4a;
  localparam logic [23:0] IDX_MODE_CONTROL = 24'hffff4c;
  localparam logic [23:0] IDX_INTERRUPT_CONTROL = 24'hffff4e;
  localparam logic [23:0] IDX_PENDING_CLEAR = 24'hffff50;

  // Mode control fields
  localparam int MC_UNIT_ENABLE = 7;
  localparam int MC_OUTPUT_LEVEL = 6;
  localparam int MC_PIN_A_ENABLE = 4;
  localparam int MC_EDGE_POLARITY = 2;
  localparam int MC_MODE_LO = 0;
  localparam logic [7:0] MC_WRITE_MASK = 8'hd7;

  // Source select fields
  localparam int SS_ONE_LO = 0;
  localparam int SS_TWO_LO = 3;
  localparam logic [7:0] SS_WRITE_MASK = 8'h3f;
  localparam logic [2:0] SRC_STOPPED = 3'h0;
  localparam logic [2:0] SRC_PRESCALED = 3'h1;
  localparam logic [2:0] SRC_SLOW = 3'h4;

  // Interrupt control fields
  localparam int IC_ENABLE_LO = 4;
  localparam int IC_PENDING_LO = 0;

  // Widths, reset values and fixed data
  localparam int DIV_W = 5;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] PRESET_VALUE = 16'hffff;
  localparam logic [7:0] CLEAR_READ_VALUE = 8'hff;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_PWM = 2'b00,
    MODE_CAPTURE = 2'b01,
    MODE_DUAL = 2'b10,
    MODE_RESERVED = 2'b11
  } dtpc_mode_t;

endpackage

/* File: verilog/dtpc_timer.sv */
// Dual 16-bit down-counter timer with PWM toggle output and pin capture.
// Assumes an APB master on pclk, and pin inputs and slow clock that are
// synchronous-domain levels; the pin itself is still resynchronised.
//
// Register access over APB is this design's own decision.

// Functional notes
// - With pin enabled in PWM-capable mode, pin toggles on every counter one underflow.
// - Toggle output starts from output-level bit; software sets it before starting.
// - Toggle output only in PWM and dual modes, never in capture mode.
// - PWM: A reload from A, B reload from B, C unused, D counter two underflow.
// - Capture: A pin A, B pin B, C counter one underflow, D counter two underflow.
// - Dual: A on counter one reload, D on counter two reload; B, C unused.
// - Capture edge copies counter one into A; pin enable then presets counter to ones.
// - Pin enable clear: no drive, no toggle, no preset from the pin.
// - Prescaled tick divides system clock by divider value plus one, one to 32.
// - Source 001 or 100 starts a counter; zero or a reserved source keeps it stopped.
// - Source codes: 000 stopped, 001 prescaled, 100 slow; others reserved, both counters.
// - Reset leaves counters and reload/capture registers untouched.
// - Register A serves counter one, register B reloads counter two.
// - Mode 00 PWM, 01 capture, 10 dual, 11 reserved.
// - Edge polarity 0 captures falling edges, 1 rising edges.
// - Output level follows hardware toggles; software write wins a conflict.
// - Output level has no effect while the pin is an input.
// - Unit disabled: clocks stop, counter, register and pending writes ignored.
// - Clearing unit enable zeros prescaler and pending flags, pin becomes input.
// - Pending A, B, C form interrupt one; D forms interrupt two.
// - Flags clear by writing 1 to the clear register, or by clearing unit enable.
// - PWM reloads alternate A then B, A first after source 000, unit disable or a non-PWM mode; a reserved source keeps the order.
// - Interrupt control: enables D..A in bits 7..4, flags D..A in 3..0, reset clear.
module dtpc_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_pin_a_in,
  output logic timer_pin_a_out,
  output logic timer_pin_a_oe_n,
  input wire logic capture_pin_b_in,
  input wire logic slow_clock_in,
  output logic timer_irq_one,
  output logic timer_irq_two
);

  // Address match against a register index
  function automatic logic addr_hit(input logic [31:0] a, input logic [23:0] idx);
    addr_hit = (a == {6'h00, idx, 2'b00});
  endfunction

  // Tick decode shared by both counters; reserved codes never tick
  function automatic logic source_tick(input logic [2:0] src, input logic psc,
                                       input logic slow);
    unique case (src)
      dtpc_pkg::SRC_PRESCALED: source_tick = psc;
      dtpc_pkg::SRC_SLOW: source_tick = slow;
      default: source_tick = 1'b0;
    endcase
  endfunction

  // Control state, reset by presetn
  logic [7:0] mode_control;
  logic [7:0] source_select;
  logic [dtpc_pkg::DIV_W-1:0] divider_value;
  logic [dtpc_pkg::DIV_W-1:0] prescale_count;
  logic [3:0] int_enable;
  logic [3:0] pending;
  logic reload_from_b;
  logic pin_a_meta;
  logic pin_a_sync;
  logic pin_a_prev;
  logic pin_b_meta;
  logic pin_b_sync;
  logic pin_b_prev;
  logic slow_prev;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] next_prdata;
  logic next_oe_n;
  logic next_irq_one;
  logic next_irq_two;
  logic [7:0] next_mode_control;
  logic [7:0] next_source_select;
  logic [dtpc_pkg::DIV_W-1:0] next_divider_value;
  logic [dtpc_pkg::DIV_W-1:0] next_prescale_count;
  logic [3:0] next_int_enable;
  logic [3:0] next_pending;
  logic next_reload_from_b;

  // Data state, deliberately without reset
  logic [15:0] counter_one;
  logic [15:0] counter_two;
  logic [15:0] reload_capture_reg_a;
  logic [15:0] reload_reg_b;
  logic [15:0] next_counter_one;
  logic [15:0] next_counter_two;
  logic [15:0] next_reload_capture_reg_a;
  logic [15:0] next_reload_reg_b;

  // Decoded views
  dtpc_pkg::dtpc_mode_t operating_mode_field;
  logic unit_enable;
  logic pin_a_enable;
  logic pin_edge_polarity;
  logic [2:0] counter_one_source;
  logic [2:0] counter_two_source;
  logic setup;
  logic wr;
  logic psc_tick;
  logic slow_tick;
  logic tick_one;
  logic tick_two;
  logic uflow_one;
  logic uflow_two;
  logic toggle_mode;
  logic edge_a;
  logic edge_b;
  logic capture_a;
  logic capture_b;
  logic toggle_pin;
  logic [3:0] hw_set;
  logic [3:0] sw_set;
  logic [3:0] sw_clr;
  logic next_unit_enable;

  // Field views of the mode and source registers
  assign operating_mode_field = dtpc_pkg::dtpc_mode_t'(mode_control[1:0]);
  assign unit_enable = mode_control[dtpc_pkg::MC_UNIT_ENABLE];
  assign pin_a_enable = mode_control[dtpc_pkg::MC_PIN_A_ENABLE];
  assign pin_edge_polarity = mode_control[dtpc_pkg::MC_EDGE_POLARITY];
  assign counter_one_source = source_select[dtpc_pkg::SS_ONE_LO +: 3];
  assign counter_two_source = source_select[dtpc_pkg::SS_TWO_LO +: 3];

  // Bus phases: answer is prepared in setup, write lands in access
  assign setup = psel & ~penable;
  assign wr = psel & penable & pready & pwrite;

  // Tick generation; a stopped unit gates every counter clock
  assign psc_tick = unit_enable & (prescale_count == divider_value);
  assign slow_tick = unit_enable & slow_clock_in & ~slow_prev;
  assign tick_one = unit_enable & source_tick(counter_one_source, psc_tick, slow_tick);
  assign tick_two = unit_enable & source_tick(counter_two_source, psc_tick, slow_tick);
  assign uflow_one = tick_one & (counter_one == 16'h0000);
  assign uflow_two = tick_two & (counter_two == 16'h0000);

  // Edge seen only between the settled sync stage and its history
  assign edge_a = pin_edge_polarity ? (pin_a_sync & ~pin_a_prev)
                                    : (~pin_a_sync & pin_a_prev);
  assign edge_b = pin_edge_polarity ? (pin_b_sync & ~pin_b_prev)
                                    : (~pin_b_sync & pin_b_prev);
  assign capture_a = unit_enable & (operating_mode_field == dtpc_pkg::MODE_CAPTURE) & edge_a;
  assign capture_b = unit_enable & (operating_mode_field == dtpc_pkg::MODE_CAPTURE) & edge_b;

  // Toggle output exists in PWM and dual modes only
  assign toggle_mode = (operating_mode_field == dtpc_pkg::MODE_PWM) |
                       (operating_mode_field == dtpc_pkg::MODE_DUAL);
  assign toggle_pin = uflow_one & toggle_mode & pin_a_enable;

  // Hardware events per mode, indexed D C B A
  always_comb begin
    hw_set = 4'h0;
    unique case (operating_mode_field)
      dtpc_pkg::MODE_PWM: begin
        hw_set[0] = uflow_one & ~reload_from_b;
        hw_set[1] = uflow_one & reload_from_b;
        hw_set[3] = uflow_two;
      end
      dtpc_pkg::MODE_CAPTURE: begin
        hw_set[0] = capture_a;
        hw_set[1] = capture_b;
        hw_set[2] = uflow_one;
        hw_set[3] = uflow_two;
      end
      dtpc_pkg::MODE_DUAL: begin
        hw_set[0] = uflow_one;
        hw_set[3] = uflow_two;
      end
      dtpc_pkg::MODE_RESERVED: begin
        hw_set = 4'h0;
      end
    endcase
  end

  // Control next values
  always_comb begin
    next_mode_control = mode_control;
    next_source_select = source_select;
    next_divider_value = divider_value;
    next_prescale_count = prescale_count;
    next_int_enable = int_enable;
    next_pending = pending;
    next_reload_from_b = reload_from_b;
    sw_set = 4'h0;
    sw_clr = 4'h0;
    // Hardware toggle first, so a same-cycle write overrides it
    if (toggle_pin) begin
      next_mode_control[dtpc_pkg::MC_OUTPUT_LEVEL] = ~mode_control[dtpc_pkg::MC_OUTPUT_LEVEL];
    end
    if (wr && addr_hit(paddr, dtpc_pkg::IDX_MODE_CONTROL)) begin
      next_mode_control = pwdata[7:0] & dtpc_pkg::MC_WRITE_MASK;
    end
    if (wr && addr_hit(paddr, dtpc_pkg::IDX_SOURCE_SELECT)) begin
      next_source_select = pwdata[7:0] & dtpc_pkg::SS_WRITE_MASK;
    end
    if (wr && addr_hit(paddr, dtpc_pkg::IDX_CLOCK_DIVIDER)) begin
      next_divider_value = pwdata[dtpc_pkg::DIV_W-1:0];
    end
    // Prescaler counts 0..divider_value, one tick per wrap
    if (psc_tick) begin
      next_prescale_count = '0;
    end else if (unit_enable) begin
      next_prescale_count = prescale_count + 1'b1;
    end
    if (wr && addr_hit(paddr, dtpc_pkg::IDX_INTERRUPT_CONTROL)) begin
      next_int_enable = pwdata[dtpc_pkg::IC_ENABLE_LO +: 4];
      if (unit_enable) begin
        sw_set = pwdata[dtpc_pkg::IC_PENDING_LO +: 4];
      end
    end
    if (wr && addr_hit(paddr, dtpc_pkg::IDX_PENDING_CLEAR) && unit_enable) begin
      sw_clr = pwdata[3:0];
    end
    // Set beats clear so an event in the clearing cycle survives
    next_pending = (pending & ~sw_clr) | sw_set | hw_set;
    // PWM reload alternation restarts from A when counter one's source is stopped, the unit is off or the mode is not PWM
    if (!unit_enable || counter_one_source == dtpc_pkg::SRC_STOPPED ||
        operating_mode_field != dtpc_pkg::MODE_PWM) begin
      next_reload_from_b = 1'b0;
    end else if (uflow_one) begin
      next_reload_from_b = ~reload_from_b;
    end
    // Disabling the unit wipes prescaler and pending flags
    next_unit_enable = next_mode_control[dtpc_pkg::MC_UNIT_ENABLE];
    if (!unit_enable || !next_unit_enable) begin
      next_divider_value = '0;
      next_prescale_count = '0;
      next_pending = 4'h0;
    end
  end

  // Output and bus answer next values, all registered
  always_comb begin
    next_pready = setup;
    next_pslverr = 1'b0;
    next_prdata = dtpc_pkg::UNMAPPED_READ;
    // Pin is driven only in a toggle mode with the pin and unit enabled
    next_oe_n = ~(next_mode_control[dtpc_pkg::MC_UNIT_ENABLE] &
                  next_mode_control[dtpc_pkg::MC_PIN_A_ENABLE] &
                  ((next_mode_control[1:0] == dtpc_pkg::MODE_PWM) |
                   (next_mode_control[1:0] == dtpc_pkg::MODE_DUAL)));
    next_irq_one = |(next_pending[2:0] & next_int_enable[2:0]);
    next_irq_two = next_pending[3] & next_int_enable[3];
    if (setup) begin
      if (addr_hit(paddr, dtpc_pkg::IDX_COUNTER_ONE)) begin
        next_prdata = {16'h0000, counter_one};
      end else if (addr_hit(paddr, dtpc_pkg::IDX_RELOAD_CAPTURE_A)) begin
        next_prdata = {16'h0000, reload_capture_reg_a};
      end else if (addr_hit(paddr, dtpc_pkg::IDX_RELOAD_B)) begin
        next_prdata = {16'h0000, reload_reg_b};
      end else if (addr_hit(paddr, dtpc_pkg::IDX_COUNTER_TWO)) begin
        next_prdata = {16'h0000, counter_two};
      end else if (addr_hit(paddr, dtpc_pkg::IDX_CLOCK_DIVIDER)) begin
        next_prdata = {27'h0000000, divider_value};
      end else if (addr_hit(paddr, dtpc_pkg::IDX_SOURCE_SELECT)) begin
        next_prdata = {24'h000000, source_select};
      end else if (addr_hit(paddr, dtpc_pkg::IDX_MODE_CONTROL)) begin
        next_prdata = {24'h000000, mode_control};
      end else if (addr_hit(paddr, dtpc_pkg::IDX_INTERRUPT_CONTROL)) begin
        next_prdata = {24'h000000, int_enable, pending};
      end else if (addr_hit(paddr, dtpc_pkg::IDX_PENDING_CLEAR)) begin
        next_prdata = {24'h000000, dtpc_pkg::CLEAR_READ_VALUE};
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  // Control registers and synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_control <= dtpc_pkg::CTRL_RESET;
      source_select <= dtpc_pkg::CTRL_RESET;
      divider_value <= '0;
      prescale_count <= '0;
      int_enable <= 4'h0;
      pending <= 4'h0;
      reload_from_b <= 1'b0;
      pin_a_meta <= 1'b0;
      pin_a_sync <= 1'b0;
      pin_a_prev <= 1'b0;
      pin_b_meta <= 1'b0;
      pin_b_sync <= 1'b0;
      pin_b_prev <= 1'b0;
      slow_prev <= 1'b0;
      prdata <= dtpc_pkg::UNMAPPED_READ;
      pready <= 1'b0;
      pslverr <= 1'b0;
      timer_pin_a_oe_n <= 1'b1;
      timer_irq_one <= 1'b0;
      timer_irq_two <= 1'b0;
    end else begin
      mode_control <= next_mode_control;
      source_select <= next_source_select;
      divider_value <= next_divider_value;
      prescale_count <= next_prescale_count;
      int_enable <= next_int_enable;
      pending <= next_pending;
      reload_from_b <= next_reload_from_b;
      pin_a_meta <= timer_pin_a_in;
      pin_a_sync <= pin_a_meta;
      pin_a_prev <= pin_a_sync;
      pin_b_meta <= capture_pin_b_in;
      pin_b_sync <= pin_b_meta;
      pin_b_prev <= pin_b_sync;
      slow_prev <= slow_clock_in;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      timer_pin_a_oe_n <= next_oe_n;
      timer_irq_one <= next_irq_one;
      timer_irq_two <= next_irq_two;
    end
  end

  // The pin level is the output-level flip-flop itself
  assign timer_pin_a_out = mode_control[dtpc_pkg::MC_OUTPUT_LEVEL];

  // Counter and reload/capture next values
  always_comb begin
    next_counter_one = counter_one;
    next_counter_two = counter_two;
    next_reload_capture_reg_a = reload_capture_reg_a;
    next_reload_reg_b = reload_reg_b;
    // Counter one: reload on underflow in PWM and dual modes; capture and reserved modes wrap
    if (tick_one) begin
      if (uflow_one && operating_mode_field == dtpc_pkg::MODE_PWM) begin
        next_counter_one = reload_from_b ? reload_reg_b : reload_capture_reg_a;
      end else if (uflow_one && operating_mode_field == dtpc_pkg::MODE_DUAL) begin
        next_counter_one = reload_capture_reg_a;
      end else begin
        next_counter_one = counter_one - 16'h0001;
      end
    end
    // Capture copies the present count, then optionally presets
    if (capture_a) begin
      next_reload_capture_reg_a = counter_one;
      if (pin_a_enable) begin
        next_counter_one = dtpc_pkg::PRESET_VALUE;
      end
    end
    // Counter two reloads from register B in every mode
    if (tick_two) begin
      if (uflow_two) begin
        next_counter_two = reload_reg_b;
      end else begin
        next_counter_two = counter_two - 16'h0001;
      end
    end
    // Software writes win over counting, but only while enabled
    if (wr && unit_enable) begin
      if (addr_hit(paddr, dtpc_pkg::IDX_COUNTER_ONE)) begin
        next_counter_one = pwdata[15:0];
      end
      if (addr_hit(paddr, dtpc_pkg::IDX_RELOAD_CAPTURE_A)) begin
        next_reload_capture_reg_a = pwdata[15:0];
      end
      if (addr_hit(paddr, dtpc_pkg::IDX_RELOAD_B)) begin
        next_reload_reg_b = pwdata[15:0];
      end
      if (addr_hit(paddr, dtpc_pkg::IDX_COUNTER_TWO)) begin
        next_counter_two = pwdata[15:0];
      end
    end
  end

  // No reset here: counts survive reset, power-up value is unknown
  always_ff @(posedge pclk) begin
    counter_one <= next_counter_one;
    counter_two <= next_counter_two;
    reload_capture_reg_a <= next_reload_capture_reg_a;
    reload_reg_b <= next_reload_reg_b;
  end

endmodule

/* File: verif/dtpc_pin_partner.sv */
// External signal source on the timer pins, standing in for the far side.
// Assumes the bench sets drive_a and drive_b at clock edges and holds them.
module dtpc_pin_partner (
  input wire logic pin_out,
  input wire logic pin_oe_n,
  input wire logic drive_a,
  input wire logic drive_b,
  output logic pin_a,
  output logic pin_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pin level: the device wins while it drives, the source otherwise
  assign pin_a = pin_oe_n ? drive_a : pin_out;
  // Levels are held for many cycles, never a sub-cycle glitch
  assign pin_b = drive_b;
endmodule

/* File: verif/dtpc_timer_chk.sv */
// Checker for the timer unit: APB answers, pin drive and interrupt quiet.
// Assumes it is bound to dtpc_timer and sees only that module's ports.
module dtpc_timer_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_pin_a_in,
  input wire logic timer_pin_a_out,
  input wire logic timer_pin_a_oe_n,
  input wire logic capture_pin_b_in,
  input wire logic slow_clock_in,
  input wire logic timer_irq_one,
  input wire logic timer_irq_two
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_MODE = {6'h0, dtpc_pkg::IDX_MODE_CONTROL, 2'b00};
  localparam logic [31:0] A_DIV = {6'h0, dtpc_pkg::IDX_CLOCK_DIVIDER, 2'b00};
  localparam logic [31:0] A_CLR = {6'h0, dtpc_pkg::IDX_PENDING_CLEAR, 2'b00};
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic mapped;
  logic pin_ok;
  // Shadow of the mode byte, updated only by accepted writes
  always_comb begin
    next_ctrl = ctrl;
    if (psel && penable && pready && pwrite && !pslverr && paddr == A_MODE) begin
      next_ctrl = pwdata[7:0] & 8'hd7;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 8'h00;
    end else begin
      ctrl <= next_ctrl;
    end
  end
  // Address decode and the only settings that may drive the pin
  assign mapped = paddr[31:26] == 6'h0 && paddr[1:0] == 2'h0 && paddr[25:2] inside {
    dtpc_pkg::IDX_COUNTER_ONE, dtpc_pkg::IDX_RELOAD_CAPTURE_A, dtpc_pkg::IDX_RELOAD_B,
    dtpc_pkg::IDX_COUNTER_TWO, dtpc_pkg::IDX_CLOCK_DIVIDER, dtpc_pkg::IDX_SOURCE_SELECT,
    dtpc_pkg::IDX_MODE_CONTROL, dtpc_pkg::IDX_INTERRUPT_CONTROL, dtpc_pkg::IDX_PENDING_CLEAR};
  assign pin_ok = ctrl[7] && ctrl[4] && !ctrl[0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_error_on_unmapped: assert property (pready |-> pslverr == !mapped)
    else $error("pslverr does not match decode");
  a_clear_reads_ones: assert property (pready && !pwrite && paddr == A_CLR |->
    prdata == 32'h0000_00ff) else $error("clear register read wrong");
  a_upper_bits_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  a_divider_off: assert property (pready && !pwrite && paddr == A_DIV && !ctrl[7] &&
    $past(!ctrl[7], 2) |-> prdata == 32'h0) else $error("divider not zero");
  a_mode_readback: assert property (pready && !pwrite && paddr == A_MODE |->
    (prdata[7:0] & 8'hbf) == (ctrl & 8'h97)) else $error("mode byte wrong");
  a_pin_needs_enable: assert property (!timer_pin_a_oe_n |-> pin_ok || $past(pin_ok))
    else $error("pin driven while not allowed");
  a_irq_quiet_off: assert property (!ctrl[7] && $past(!ctrl[7]) |->
    !timer_irq_one && !timer_irq_two) else $error("interrupt while disabled");
  c_unmapped: cover property (pready && pslverr);
  c_pin_flip: cover property (!timer_pin_a_oe_n ##1 $changed(timer_pin_a_out));
  c_irq_two: cover property ($rose(timer_irq_two));
endmodule
bind dtpc_timer dtpc_timer_chk u_dtpc_timer_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_pin_a_in(timer_pin_a_in),
  .timer_pin_a_out(timer_pin_a_out), .timer_pin_a_oe_n(timer_pin_a_oe_n),
  .capture_pin_b_in(capture_pin_b_in), .slow_clock_in(slow_clock_in),
  .timer_irq_one(timer_irq_one), .timer_irq_two(timer_irq_two));

/* File: verif/test_dual_timer_pwm_capture_unit.sv */
// Self-checking bench for the timer unit: registers, PWM, capture, dual mode.
// Assumes dtpc_timer, its package and the pin partner model are compiled first.
module test_dual_timer_pwm_capture_unit;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [23:0] C1 = dtpc_pkg::IDX_COUNTER_ONE;
  localparam logic [23:0] C2 = dtpc_pkg::IDX_COUNTER_TWO;
  localparam logic [23:0] RA = dtpc_pkg::IDX_RELOAD_CAPTURE_A;
  localparam logic [23:0] RB = dtpc_pkg::IDX_RELOAD_B;
  localparam logic [23:0] DV = dtpc_pkg::IDX_CLOCK_DIVIDER;
  localparam logic [23:0] SS = dtpc_pkg::IDX_SOURCE_SELECT;
  localparam logic [23:0] MC = dtpc_pkg::IDX_MODE_CONTROL;
  localparam logic [23:0] IC = dtpc_pkg::IDX_INTERRUPT_CONTROL;
  localparam logic [23:0] CL = dtpc_pkg::IDX_PENDING_CLEAR;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, pin_a, pin_b, pin_out, oe_n, irq_one, irq_two, err;
  logic drive_a = 1'b0;
  logic drive_b = 1'b0;
  logic [3:0] slow_div = 4'h0;
  int errors = 0;
  int n_compared = 0;

  // Clock, and a slow tick source rising once every sixteen cycles
  always #12.5 pclk = ~pclk;
  always @(posedge pclk) slow_div <= slow_div + 4'h1;

  dtpc_timer u_dtpc_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_pin_a_in(pin_a), .timer_pin_a_out(pin_out),
    .timer_pin_a_oe_n(oe_n), .capture_pin_b_in(pin_b), .slow_clock_in(slow_div[3]),
    .timer_irq_one(irq_one), .timer_irq_two(irq_two));
  dtpc_pin_partner u_dtpc_pin_partner (.pin_out(pin_out), .pin_oe_n(oe_n),
    .drive_a(drive_a), .drive_b(drive_b), .pin_a(pin_a), .pin_b(pin_b));

  task automatic conclude();
    if (errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One APB transfer; the request stands until pready is seen at an edge
  task automatic xfer(input logic w, input logic [23:0] idx, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {6'h0, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("pready", 32'h1, {31'h0, pready});
  endtask
  task automatic wr(input logic [23:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask
  task automatic rdchk(input logic [23:0] idx, input logic [31:0] exp, input string name);
    xfer(1'b0, idx, 32'h0);
    check(name, exp, rd);
  endtask
  // Cycles until the pin output flips, 400 meaning it never did
  task automatic wait_flip(output int cyc);
    logic last;
    last = pin_out;
    cyc = 0;
    do begin
      @(posedge pclk);
      #1;
      cyc++;
    end while (pin_out === last && cyc < 400);
  endtask

  task automatic t_reset();
    rdchk(MC, 32'h0, "mode_control");
    rdchk(IC, 32'h0, "interrupt_control");
    rdchk(SS, 32'h0, "source_select");
    rdchk(CL, 32'hff, "pending_clear");
    xfer(1'b0, 24'h000123, 32'h0);
    check("unmapped_error", 32'h1, {31'h0, err});
    check("pin_oe_n", 32'h1, {31'h0, oe_n});
  endtask
  // Writes while disabled are dropped; a reset keeps counter and reload values
  task automatic t_hold();
    wr(MC, 32'h80);
    wr(C1, 32'h1234);
    wr(RA, 32'h5678);
    wr(DV, 32'h1f);
    wr(MC, 32'h00);
    wr(C1, 32'h0bad);
    wr(IC, 32'h0f);
    wr(DV, 32'h03);
    rdchk(C1, 32'h1234, "counter_one_locked");
    rdchk(IC, 32'h0, "pending_locked");
    rdchk(DV, 32'h0, "divider_cleared");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(RA, 32'h5678, "reload_a_kept");
    rdchk(C1, 32'h1234, "counter_one_kept");
  endtask
  // PWM toggling: reload A gives four ticks, reload B six, A first each start
  task automatic t_pwm(input logic [4:0] dv);
    int c1, c2;
    wr(MC, 32'h80);
    wr(SS, 32'h0);
    wr(RA, 32'h3);
    wr(RB, 32'h5);
    wr(C1, 32'h0);
    wr(DV, {27'h0, dv});
    wr(IC, 32'h30);
    wr(MC, 32'hd0);
    @(posedge pclk);
    #1;
    check("start_level", 32'h1, {31'h0, pin_out});
    check("pwm_oe_n", 32'h0, {31'h0, oe_n});
    wr(SS, 32'h1);
    wait_flip(c1);
    wait_flip(c1);
    wait_flip(c2);
    check("reload_a_span", 4 * (dv + 1), c1);
    check("reload_b_span", 6 * (dv + 1), c2);
    wr(SS, 32'h0);
    rdchk(MC, 32'h90, "level_follows_pin");
    rdchk(IC, 32'h33, "pwm_flags");
    check("irq_one_set", 32'h1, {31'h0, irq_one});
    wr(CL, 32'h0);
    rdchk(IC, 32'h33, "clear_by_zero");
    wr(CL, 32'h3);
    rdchk(IC, 32'h30, "clear_by_one");
    check("irq_one_clear", 32'h0, {31'h0, irq_one});
  endtask
  // Capture on rising edges, preset only with the pin enabled, pin B flag
  task automatic t_capture();
    wr(MC, 32'h80);
    wr(SS, 32'h0);
    wr(C1, 32'h0042);
    wr(IC, 32'h0);
    wr(CL, 32'hf);
    wr(MC, 32'hd5);
    drive_a <= 1'b1;
    repeat (5) @(posedge pclk);
    check("capture_oe_n", 32'h1, {31'h0, oe_n});
    rdchk(RA, 32'h0042, "captured");
    rdchk(C1, 32'hffff, "preset");
    rdchk(IC, 32'h1, "flag_a");
    wr(C1, 32'h0011);
    drive_a <= 1'b0;
    repeat (5) @(posedge pclk);
    rdchk(RA, 32'h0042, "falling_ignored");
    wr(MC, 32'h85);
    drive_a <= 1'b1;
    repeat (5) @(posedge pclk);
    rdchk(RA, 32'h0011, "captured_no_pin");
    rdchk(C1, 32'h0011, "no_preset");
    drive_b <= 1'b1;
    repeat (5) @(posedge pclk);
    drive_b <= 1'b0;
    repeat (5) @(posedge pclk);
    rdchk(IC, 32'h3, "flag_b");
  endtask
  // Dual mode on the slow clock, a reserved source, then unit disable
  task automatic t_dual();
    int c;
    wr(MC, 32'h80);
    wr(SS, 32'h0);
    wr(CL, 32'hf);
    wr(DV, 32'h0);
    wr(RA, 32'h1);
    wr(C1, 32'h0);
    wr(RB, 32'h2);
    wr(C2, 32'h0);
    wr(IC, 32'h80);
    wr(MC, 32'h92);
    wr(SS, 32'h0c);
    wait_flip(c);
    wait_flip(c);
    check("slow_span", 32'd32, c);
    check("irq_two_set", 32'h1, {31'h0, irq_two});
    rdchk(IC, 32'h89, "dual_flags");
    wr(SS, 32'h02);
    wait_flip(c);
    check("reserved_stops", 32'd400, c);
    wr(MC, 32'h00);
    repeat (3) @(posedge pclk);
    check("irq_two_off", 32'h0, {31'h0, irq_two});
    check("pin_released", 32'h1, {31'h0, oe_n});
    rdchk(IC, 32'h80, "pending_zeroed");
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_hold();
    t_pwm(5'h00);
    t_pwm(5'h1f);
    t_capture();
    t_dual();
    conclude();
  end
  // Watchdog well beyond the thousand or so cycles the scenarios need
  initial begin
    #500us;
    errors++;
    conclude();
  end
endmodule
